/* File: sio_io_cond.sv */
// servo connector io conditioning: apb registers, pin synchronisers,
// debounce filters, active level, function allocation and output negation.
// assumes an apb master on clk and asynchronous connector pins.
//
// Function
// - allocation code 1 to 8 makes the function follow that pin's valid state.
// - general inputs filtered 0 to 100 ticks of 0.1 ms, default 1, immediate.
// - alarm inputs filtered 0 to 3 ticks of 0.1 ms, default 1, immediate.
// - first level select per pin: 0 valid when low, 1 valid when high.
// - second level select covers pins 5 upward, same encoding, default zero.
// - outputs 1 to 4 each invertible, default no inversion, immediate.
`timescale 1ns/1ps
module sio_io_cond (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  control_connector_input_pin,
	output logic [3:0]       control_connector_output_pin,
	output logic [7:0]       func_active
);
	sio_pkg::sio_cfg_t cfg;
	logic [7:0]        sync1;
	logic [7:0]        sync2;
	logic [7:0]        filt_level;
	logic [7:0]        pin_valid;
	logic [7:0]        next_func;
	logic              tick;
	logic              wr_en;
	logic              hit;

	// clamp a written filter time into its legal range
	function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lim);
		clamp = (v > lim) ? lim : v;
	endfunction

	// state of one allocation code given the valid pins
	function automatic logic alloc_state(input logic [3:0] code, input logic [7:0] valid);
		logic [3:0] idx;
		idx = code - sio_pkg::ALLOC_PIN_FIRST;
		if (code == sio_pkg::ALLOC_ALWAYS) begin
			alloc_state = 1'b1;
		end else if (code >= sio_pkg::ALLOC_PIN_FIRST && code <= sio_pkg::ALLOC_PIN_LAST) begin
			alloc_state = valid[idx[2:0]];
		end else begin
			alloc_state = 1'b0;
		end
	endfunction

	function automatic logic addr_hit(input logic [7:0] a);
		case (a)
			sio_pkg::ADDR_FILT, sio_pkg::ADDR_ALARM_FILT, sio_pkg::ADDR_LVL_A,
			sio_pkg::ADDR_LVL_B, sio_pkg::ADDR_INV_A, sio_pkg::ADDR_ALLOC_LO,
			sio_pkg::ADDR_ALLOC_HI, sio_pkg::ADDR_ALARM_MASK, sio_pkg::ADDR_OUT_CTL,
			sio_pkg::ADDR_STATUS: addr_hit = 1'b1;
			default: addr_hit = 1'b0;
		endcase
	endfunction

	// apb: zero wait states, but a low ce stretches the access phase
	assign hit     = addr_hit(paddr);
	assign pready  = ce;
	assign pslverr = psel && penable && !hit;
	assign wr_en   = ce && psel && penable && pwrite && hit;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg.filt       <= sio_pkg::RST_FILT;
			cfg.alarm_filt <= sio_pkg::RST_ALARM_FILT;
			cfg.lvl_a      <= sio_pkg::RST_LVL;
			cfg.lvl_b      <= sio_pkg::RST_LVL;
			cfg.inv_a      <= sio_pkg::RST_INV;
			cfg.alloc      <= {sio_pkg::RST_ALLOC, sio_pkg::RST_ALLOC};
			cfg.alarm_mask <= sio_pkg::RST_ALARM_MASK;
			cfg.out_ctl    <= sio_pkg::RST_OUT_CTL;
		end else if (wr_en) begin
			case (paddr)
				sio_pkg::ADDR_FILT: begin
					cfg.filt <= clamp(pwdata[15:0], sio_pkg::MAX_FILT);
				end
				sio_pkg::ADDR_ALARM_FILT: begin
					cfg.alarm_filt <= clamp(pwdata[15:0], sio_pkg::MAX_ALARM_FILT);
				end
				sio_pkg::ADDR_LVL_A: begin
					cfg.lvl_a <= pwdata[15:0];
				end
				sio_pkg::ADDR_LVL_B: begin
					cfg.lvl_b <= pwdata[15:0];
				end
				sio_pkg::ADDR_INV_A: begin
					cfg.inv_a <= pwdata[15:0];
				end
				sio_pkg::ADDR_ALLOC_LO: begin
					cfg.alloc[15:0] <= pwdata[15:0];
				end
				sio_pkg::ADDR_ALLOC_HI: begin
					cfg.alloc[31:16] <= pwdata[15:0];
				end
				sio_pkg::ADDR_ALARM_MASK: begin
					cfg.alarm_mask <= pwdata[7:0];
				end
				sio_pkg::ADDR_OUT_CTL: begin
					cfg.out_ctl <= pwdata[3:0];
				end
				default: begin
				end
			endcase
		end
	end

	// read data is latched in the setup phase so prdata comes from a flop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
		end else if (ce && psel && !penable) begin
			case (paddr)
				sio_pkg::ADDR_FILT:       prdata <= {16'h0000, cfg.filt};
				sio_pkg::ADDR_ALARM_FILT: prdata <= {16'h0000, cfg.alarm_filt};
				sio_pkg::ADDR_LVL_A:      prdata <= {16'h0000, cfg.lvl_a};
				sio_pkg::ADDR_LVL_B:      prdata <= {16'h0000, cfg.lvl_b};
				sio_pkg::ADDR_INV_A:      prdata <= {16'h0000, cfg.inv_a};
				sio_pkg::ADDR_ALLOC_LO:   prdata <= {16'h0000, cfg.alloc[15:0]};
				sio_pkg::ADDR_ALLOC_HI:   prdata <= {16'h0000, cfg.alloc[31:16]};
				sio_pkg::ADDR_ALARM_MASK: prdata <= {24'h000000, cfg.alarm_mask};
				sio_pkg::ADDR_OUT_CTL:    prdata <= {28'h0000000, cfg.out_ctl};
				sio_pkg::ADDR_STATUS:     prdata <= {16'h0000, func_active, filt_level};
				default:                  prdata <= 32'h00000000;
			endcase
		end
	end

	// two-flop synchronisers on the connector pins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 8'hFF;
			sync2 <= 8'hFF;
		end else if (ce) begin
			sync1 <= control_connector_input_pin;
			sync2 <= sync1;
		end
	end

	sio_tick u_tick (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.tick  (tick)
	);

	genvar gi;
	generate
		for (gi = 0; gi < sio_pkg::NUM_IN; gi++) begin : g_in
			logic [6:0] ftime;
			logic       sel;
			// alarm pins take the short filter, the rest the general one
			assign ftime = cfg.alarm_mask[gi] ? cfg.alarm_filt[6:0] : cfg.filt[6:0];
			if (gi < 4) begin : g_a
				assign sel = cfg.lvl_a[gi*sio_pkg::DIGIT_W];
			end else begin : g_b
				assign sel = cfg.lvl_b[(gi-4)*sio_pkg::DIGIT_W];
			end
			sio_debounce u_deb (
				.clk   (clk),
				.rst_n (rst_n),
				.ce    (ce),
				.tick  (tick),
				.raw   (sync2[gi]),
				.ftime (ftime),
				.level (filt_level[gi])
			);
			// pin low is on; select 1 makes the off state the valid one
			assign pin_valid[gi] = sel ? filt_level[gi] : !filt_level[gi];
		end
		for (gi = 0; gi < sio_pkg::NUM_FUNC; gi++) begin : g_fn
			assign next_func[gi] =
				alloc_state(cfg.alloc[gi*sio_pkg::DIGIT_W +: sio_pkg::DIGIT_W], pin_valid);
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			func_active <= 8'h00;
		end else if (ce) begin
			func_active <= next_func;
		end
	end

	// outputs idle inactive; negation is applied on the way to the pin
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			control_connector_output_pin <= 4'h0;
		end else if (ce) begin
			for (int i = 0; i < sio_pkg::NUM_OUT; i++) begin
				control_connector_output_pin[i] <=
					cfg.out_ctl[i] ^ cfg.inv_a[i*sio_pkg::DIGIT_W];
			end
		end
	end

	// assertion helpers
	logic [3:0] code0;
	logic [2:0] pin0;
	assign code0 = cfg.alloc[3:0];
	assign pin0  = 3'(code0 - 4'h1);

	property p_alloc_pin;
		@(posedge clk) disable iff (!rst_n)
		(ce && code0 >= 4'h3 && code0 <= 4'h8) |=> (func_active[0] == $past(pin_valid[pin0]));
	endproperty
	a_alloc_pin: assert property (p_alloc_pin) else $error("function 0 not following pin");

	property p_filt_range;
		@(posedge clk) disable iff (!rst_n)
		(wr_en && paddr == 8'h00) |=> (cfg.filt <= 16'h0064 &&
			(cfg.filt == $past(pwdata[15:0]) || $past(pwdata[15:0]) > 16'h0064));
	endproperty
	a_filt_range: assert property (p_filt_range) else $error("filter time write wrong");

	property p_alarm_range;
		@(posedge clk) disable iff (!rst_n)
		(wr_en && paddr == 8'h04) |=> (cfg.alarm_filt <= 16'h0003 &&
			(cfg.alarm_filt == $past(pwdata[15:0]) || $past(pwdata[15:0]) > 16'h0003));
	endproperty
	a_alarm_range: assert property (p_alarm_range) else $error("alarm filter write wrong");

	property p_forced;
		@(posedge clk) disable iff (!rst_n)
		(ce && cfg.alloc[27:24] == 4'h9) |=> func_active[6];
	endproperty
	a_forced: assert property (p_forced) else $error("forced function not active");

	property p_valid_pin1;
		@(posedge clk) disable iff (!rst_n)
		pin_valid[0] == (cfg.lvl_a[0] == filt_level[0]);
	endproperty
	a_valid_pin1: assert property (p_valid_pin1) else $error("pin 1 active level wrong");

	property p_valid_pin5;
		@(posedge clk) disable iff (!rst_n)
		(cfg.lvl_b[0] && filt_level[4]) |-> pin_valid[4];
	endproperty
	a_valid_pin5: assert property (p_valid_pin5) else $error("pin 5 active level wrong");

	property p_out_neg;
		@(posedge clk) disable iff (!rst_n)
		ce |=> (control_connector_output_pin[0] == ($past(cfg.out_ctl[0]) ^ $past(cfg.inv_a[0])));
	endproperty
	a_out_neg: assert property (p_out_neg) else $error("output 1 negation wrong");

	property p_valid_pin4;
		@(posedge clk) disable iff (!rst_n)
		pin_valid[3] == (cfg.lvl_a[12] == filt_level[3]);
	endproperty
	a_valid_pin4: assert property (p_valid_pin4) else $error("pin 4 active level wrong");

	property p_valid_pin8;
		@(posedge clk) disable iff (!rst_n)
		pin_valid[7] == (cfg.lvl_b[12] == filt_level[7]);
	endproperty
	a_valid_pin8: assert property (p_valid_pin8) else $error("pin 8 active level wrong");

	// an unassigned code must leave its function inactive
	property p_func_idle;
		@(posedge clk) disable iff (!rst_n)
		(ce && code0 == 4'h0) |=> !func_active[0];
	endproperty
	a_func_idle: assert property (p_func_idle) else $error("unassigned function active");

	property p_filt_hold;
		@(posedge clk) disable iff (!rst_n)
		(ce && !(wr_en && paddr == sio_pkg::ADDR_FILT)) |=> $stable(cfg.filt);
	endproperty
	a_filt_hold: assert property (p_filt_hold) else $error("filter time changed unasked");

	property p_lvl_a_wr;
		@(posedge clk) disable iff (!rst_n)
		(wr_en && paddr == sio_pkg::ADDR_LVL_A) |=> (cfg.lvl_a == $past(pwdata[15:0]));
	endproperty
	a_lvl_a_wr: assert property (p_lvl_a_wr) else $error("level select a write lost");

	property p_lvl_b_wr;
		@(posedge clk) disable iff (!rst_n)
		(wr_en && paddr == sio_pkg::ADDR_LVL_B) |=> (cfg.lvl_b == $past(pwdata[15:0]));
	endproperty
	a_lvl_b_wr: assert property (p_lvl_b_wr) else $error("level select b write lost");

	property p_inv_wr;
		@(posedge clk) disable iff (!rst_n)
		(wr_en && paddr == sio_pkg::ADDR_INV_A) |=> (cfg.inv_a == $past(pwdata[15:0]));
	endproperty
	a_inv_wr: assert property (p_inv_wr) else $error("negation select write lost");

	property p_mask_wr;
		@(posedge clk) disable iff (!rst_n)
		(wr_en && paddr == sio_pkg::ADDR_ALARM_MASK) |=> (cfg.alarm_mask == $past(pwdata[7:0]));
	endproperty
	a_mask_wr: assert property (p_mask_wr) else $error("alarm pin mask write lost");
endmodule

/* File: sio_pkg.sv */
// package for the servo io conditioning block: register map, reset values,
// field positions and timing counts.
// assumes a 10 MHz clock and a 32-bit apb register bus.
package sio_pkg;

	localparam int NUM_IN    = 8;
	localparam int NUM_OUT   = 4;
	localparam int NUM_FUNC  = 8;
	localparam int DIGIT_W   = 4;

	// register byte offsets
	localparam logic [7:0] ADDR_FILT       = 8'h00;
	localparam logic [7:0] ADDR_ALARM_FILT = 8'h04;
	localparam logic [7:0] ADDR_LVL_A      = 8'h08;
	localparam logic [7:0] ADDR_LVL_B      = 8'h0C;
	localparam logic [7:0] ADDR_INV_A      = 8'h10;
	localparam logic [7:0] ADDR_ALLOC_LO   = 8'h14;
	localparam logic [7:0] ADDR_ALLOC_HI   = 8'h18;
	localparam logic [7:0] ADDR_ALARM_MASK = 8'h1C;
	localparam logic [7:0] ADDR_OUT_CTL    = 8'h20;
	localparam logic [7:0] ADDR_STATUS     = 8'h24;

	// reset values
	localparam logic [15:0] RST_FILT       = 16'h0001;
	localparam logic [15:0] RST_ALARM_FILT = 16'h0001;
	localparam logic [15:0] RST_LVL        = 16'h0000;
	localparam logic [15:0] RST_INV        = 16'h0000;
	localparam logic [15:0] RST_ALLOC      = 16'h0000;
	localparam logic [7:0]  RST_ALARM_MASK = 8'h00;
	localparam logic [3:0]  RST_OUT_CTL    = 4'h0;

	// ranges of the filter times, in ticks
	localparam logic [15:0] MAX_FILT       = 16'h0064;
	localparam logic [15:0] MAX_ALARM_FILT = 16'h0003;

	// allocation codes: pin numbers, and one code that forces the function on
	localparam logic [3:0] ALLOC_PIN_FIRST = 4'h1;
	localparam logic [3:0] ALLOC_PIN_LAST  = 4'h8;
	localparam logic [3:0] ALLOC_ALWAYS    = 4'h9;

	// status layout
	localparam int STAT_PIN_LSB  = 0;
	localparam int STAT_FUNC_LSB = 8;

	// filter timebase
	localparam int         CLK_NS    = 100;
	localparam int         TICK_NS   = 100000;
	localparam int         TICK_CYC  = TICK_NS / CLK_NS;
	localparam logic [9:0] TICK_LAST = 10'(TICK_CYC - 1);

	typedef struct packed {
		logic [15:0] filt;
		logic [15:0] alarm_filt;
		logic [15:0] lvl_a;
		logic [15:0] lvl_b;
		logic [15:0] inv_a;
		logic [31:0] alloc;
		logic [7:0]  alarm_mask;
		logic [3:0]  out_ctl;
	} sio_cfg_t;

endpackage

/* File: sio_tick.sv */
// 0.1 ms tick generator for the input filters.
// assumes clk at the rate held in the package; ce freezes the count.
`timescale 1ns/1ps
module sio_tick (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	output logic      tick
);
	logic [9:0] cnt;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt  <= 10'h000;
			tick <= 1'b0;
		end else if (ce) begin
			tick <= (cnt == sio_pkg::TICK_LAST);
			if (cnt == sio_pkg::TICK_LAST) begin
				cnt <= 10'h000;
			end else begin
				cnt <= cnt + 10'h001;
			end
		end
	end
endmodule

/* File: sio_debounce.sv */
// one-pin debounce filter counted in filter ticks.
// assumes raw is already synchronised to clk.
`timescale 1ns/1ps
module sio_debounce (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic       tick,
	input  wire logic       raw,
	input  wire logic [6:0] ftime,
	output logic            level
);
	logic [6:0] cnt;

	// idle pins sit high (off) through pull-ups, so that is the reset level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level <= 1'b1;
			cnt   <= 7'h00;
		end else if (ce) begin
			if (ftime == 7'h00) begin
				level <= raw;
				cnt   <= 7'h00;
			end else if (raw == level) begin
				cnt <= 7'h00;
			end else if (tick) begin
				// the first tick may land just after the change, so one tick more
				// than the setting guarantees the level held for the full time
				if (cnt >= ftime) begin
					level <= raw;
					cnt   <= 7'h00;
				end else begin
					cnt <= cnt + 7'h01;
				end
			end
		end
	end

	property p_pass_zero;
		@(posedge clk) disable iff (!rst_n)
		(ce && ftime == 7'h00) |=> (level == $past(raw));
	endproperty
	a_pass_zero: assert property (p_pass_zero) else $error("zero filter time did not pass input");

	property p_no_early;
		@(posedge clk) disable iff (!rst_n)
		(ce && ftime != 7'h00 && raw != level && !tick) |=> (level == $past(level));
	endproperty
	a_no_early: assert property (p_no_early) else $error("level accepted without a tick");
endmodule

/* File: sio_pins_model.sv */
// switch and sensor model for the connector inputs: contacts that chatter.
// assumes the bench sets the wanted levels just after a rising edge.
`timescale 1ns/1ps
module sio_pins_model (
	input  wire logic       clk,
	input  wire logic [7:0] want,
	input  wire logic [7:0] bounce,
	output logic      [7:0] pins
);
	logic [7:0] last;
	logic [7:0] left;
	logic [7:0] flip;
	// pins idle high: open contacts sit on the pull-up
	initial begin
		pins = 8'hFF;
		last = 8'hFF;
		left = 8'h00;
		flip = 8'h00;
	end
	// a change chatters for bounce cycles, so each burst is shorter than a filter tick
	always @(posedge clk) begin
		// only the contacts that move chatter, between their old and new level
		if (want !== last) begin
			flip <= want ^ last;
			last <= want;
			left <= bounce;
			pins <= (bounce != 8'h00) ? last : want;
		end else if (left != 8'h00) begin
			left <= left - 8'h01;
			pins <= left[0] ? (want ^ flip) : want;
		end else begin
			pins <= want;
		end
	end
endmodule

/* File: testbench.sv */
// self-checking bench for the io conditioning block, apb master and pin model.
// assumes a 10 MHz clock and the register map of the package.
`timescale 1ns/1ps
module testbench;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr, want, bounce, pins, func_active;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  outs;
	logic [15:0] la, lb, inv;
	logic [3:0]  ctl;
	int          miscompares, checks, cyc;
	sio_io_cond u_sio_io_cond (.clk(clk), .rst_n(rst_n), .ce(1'b1), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.control_connector_input_pin(pins), .control_connector_output_pin(outs),
		.func_active(func_active));
	sio_pins_model u_sio_pins_model (.clk(clk), .want(want), .bounce(bounce), .pins(pins));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic tally_and_finish;
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// model: level select, then allocation codes 3,4,5,6,7,8,9,1 for functions 0..7
	function automatic logic [7:0] exp_func(logic [7:0] p, logic [15:0] a, logic [15:0] b);
		logic [7:0] v;
		logic [7:0] f;
		int code[8] = '{3, 4, 5, 6, 7, 8, 9, 1};
		for (int i = 0; i < 4; i++) begin
			v[i] = a[4*i] ? p[i] : ~p[i];
			v[i+4] = b[4*i] ? p[i+4] : ~p[i+4];
		end
		for (int k = 0; k < 8; k++)
			f[k] = (code[k] <= 8) ? v[code[k]-1] : 1'b1;
		return f;
	endfunction
	initial begin
		logic [7:0]  ad[9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
		logic [31:0] rv[9] = '{1, 1, 0, 0, 0, 0, 0, 0, 0};
		rst_n = 1'b0;
		{psel, penable, pwrite} = 3'b000;
		paddr = 8'h00;
		pwdata = 32'h0;
		want = 8'hFF;
		bounce = 8'h00;
		void'($urandom(51386));
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			apb(1'b0, ad[i], 32'h0);
			chk(rd, rv[i]);
		end
		apb(1'b0, 8'h28, 32'h0);
		chk({31'h0, err}, 32'h1);
		$display("test reset_values done");
		for (int n = 0; n < 4; n++) begin
			ctl = 4'($urandom);
			inv = 16'($urandom);
			apb(1'b1, sio_pkg::ADDR_INV_A, {16'h0, inv});
			apb(1'b1, sio_pkg::ADDR_OUT_CTL, {28'h0, ctl});
			repeat (2) @(posedge clk);
			chk({28'h0, outs}, {28'h0, ctl ^ {inv[12], inv[8], inv[4], inv[0]}});
		end
		$display("test output_invert done");
		apb(1'b1, sio_pkg::ADDR_FILT, 32'h0);
		apb(1'b1, sio_pkg::ADDR_ALLOC_LO, 32'h0000_6543);
		apb(1'b1, sio_pkg::ADDR_ALLOC_HI, 32'h0000_1987);
		for (int n = 0; n < 4; n++) begin
			la = 16'($urandom);
			lb = 16'($urandom);
			apb(1'b1, sio_pkg::ADDR_LVL_A, {16'h0, la});
			apb(1'b1, sio_pkg::ADDR_LVL_B, {16'h0, lb});
			want <= 8'($urandom);
			repeat (6) @(posedge clk);
			chk({24'h0, func_active}, {24'h0, exp_func(want, la, lb)});
			apb(1'b0, sio_pkg::ADDR_LVL_B, 32'h0);
			chk(rd, {16'h0, lb});
		end
		$display("test allocation done");
		want <= 8'hFF;
		repeat (6) @(posedge clk);
		apb(1'b1, sio_pkg::ADDR_FILT, 32'h2);
		bounce <= 8'd40;
		want <= 8'hFB;
		repeat (940) @(posedge clk);
		apb(1'b0, sio_pkg::ADDR_STATUS, 32'h0);
		chk({24'h0, rd[7:0]}, 32'hFF);
		repeat (2200) @(posedge clk);
		apb(1'b0, sio_pkg::ADDR_STATUS, 32'h0);
		chk({24'h0, rd[7:0]}, 32'hFB);
		bounce <= 8'h00;
		want <= 8'hF3;
		repeat (500) @(posedge clk);
		want <= 8'hFB;
		repeat (2200) @(posedge clk);
		apb(1'b0, sio_pkg::ADDR_STATUS, 32'h0);
		chk({24'h0, rd[7:0]}, 32'hFB);
		$display("test debounce done");
		apb(1'b1, sio_pkg::ADDR_FILT, 32'd200);
		apb(1'b0, sio_pkg::ADDR_FILT, 32'h0);
		chk(rd, 32'd100);
		apb(1'b1, sio_pkg::ADDR_ALARM_FILT, 32'h7);
		apb(1'b0, sio_pkg::ADDR_ALARM_FILT, 32'h0);
		chk(rd, 32'h3);
		apb(1'b1, sio_pkg::ADDR_ALARM_FILT, 32'h1);
		apb(1'b1, sio_pkg::ADDR_ALARM_MASK, 32'h2);
		want <= 8'hF8;
		repeat (2100) @(posedge clk);
		apb(1'b0, sio_pkg::ADDR_STATUS, 32'h0);
		chk({24'h0, rd[7:0]}, 32'hF9);
		$display("test alarm_filter done");
		tally_and_finish();
	end
endmodule
